// ---- common/ptsrw_pkg.sv ----
/*
 * Constants and types for the precision-time timestamp rewrite block.
 * Assumes one datapath clock and an AXI4-Lite master for the registers.
 */
package ptsrw_pkg;
   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_PATH = 8'h04;
   localparam logic [7:0] REG_ASYM = 8'h08;
   localparam logic [7:0] REG_LCORR = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_FTS = 8'h14;
   localparam logic [7:0] REG_ID0 = 8'h18;
   localparam logic [7:0] REG_ID1 = 8'h1C;
   localparam logic [7:0] REG_ID2 = 8'h20;
   localparam logic [7:0] REG_POP = 8'h24;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_TWO_STEP_BIT = 1;
   localparam int CTRL_ID_RSV_BIT = 2;
   localparam int STAT_EMPTY_BIT = 0;
   localparam int STAT_OVF_BIT = 1;
   localparam int STAT_CNT_LSB = 8;
   localparam logic [2:0] CTRL_RST = 3'h1;
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ---------------------------------------------------------------
   // Frame geometry and timing
   // ---------------------------------------------------------------
   localparam logic [7:0] CF_OFS = 8'h08;
   localparam logic [7:0] RSV_OFS = 8'h10;
   localparam logic [3:0] CF_SIZE = 4'h8;
   localparam logic [3:0] RSV_SIZE = 4'h4;
   localparam logic [3:0] NO_SIZE = 4'h0;
   localparam int ID_W = 80;
   localparam int TS_W = 32;
   localparam int PIPE_LAT = 2;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ACT_NONE = 3'b000,
      ACT_WRITE = 3'b001,
      ACT_WRITE_SAVE = 3'b010,
      ACT_ADD = 3'b011,
      ACT_SUB_PEER = 3'b100
   } ptsrw_act_t;
   typedef enum logic [1:0] {
      FT_SYNC = 2'b00,
      FT_DELAY_REQ = 2'b01,
      FT_PDELAY_REQ = 2'b10,
      FT_PDELAY_RESP = 2'b11
   } ptsrw_ftype_t;
endpackage

// ---- core/ptsrw_core.sv ----
/*
 * Timestamp action, replacement value and FIFO register access.
 * Assumes the analyzer and capture logic share ref_clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
module ptsrw_core
   import ptsrw_pkg::*;
#(
   parameter int FIFO_DEPTH_LOG2 = 3
)
(
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic frm_valid_i,
   input wire logic frm_match_i,
   input wire logic frm_egress_i,
   input wire logic [1:0] frm_type_i,
   input wire logic [7:0] frm_hdr_ofs_i,
   input wire logic [63:0] frm_cf_i,
   input wire logic [ID_W-1:0] frm_id_i,
   input wire logic [31:0] frm_rsv_i,
   input wire logic [31:0] raw_capture_nanoseconds_i,
   output logic rw_valid_o,
   output ptsrw_act_t rw_action_o,
   output logic [7:0] rw_offset_o,
   output logic [3:0] rw_size_o,
   output logic [63:0] rw_field_o,
   output logic save_timestamp_o,
   output logic aux_valid_o,
   output logic [7:0] aux_offset_o,
   output logic [3:0] aux_size_o,
   output logic [63:0] aux_field_o
);
   typedef struct packed {
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [2:0] ctrl;
      logic [31:0] path_delay;
      logic [31:0] asym;
      logic [31:0] local_corr;
      logic ovf;
      logic pop;
      logic s1_v;
      ptsrw_act_t s1_act;
      logic [7:0] s1_ofs;
      logic [3:0] s1_size;
      logic [63:0] s1_cf;
      logic [31:0] s1_cur;
      logic [31:0] s1_adj;
      logic [ID_W-1:0] s1_id;
      logic s1_aux_v;
      logic [7:0] s1_aux_ofs;
      logic [3:0] s1_aux_size;
      logic [63:0] s1_aux_val;
      logic o_v;
      ptsrw_act_t o_act;
      logic [7:0] o_ofs;
      logic [3:0] o_size;
      logic [63:0] o_field;
      logic o_save;
      logic [ID_W-1:0] o_id;
      logic o_aux_v;
      logic [7:0] o_aux_ofs;
      logic [3:0] o_aux_size;
      logic [63:0] o_aux_val;
   } ptsrw_state_t;
   ptsrw_state_t r, n;
   logic [ID_W+TS_W-1:0] fifo_head;
   logic fifo_ready;
   logic fifo_empty;
   logic [FIFO_DEPTH_LOG2:0] fifo_cnt;
   logic fifo_drop;
   logic [31:0] cur_ns;
   logic [31:0] adj_ns;

   function automatic logic [7:0] word_addr(input logic [7:0] a);
      word_addr = {a[7:2], 2'b00};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      merge = old;
      for (int b = 0; b < 4; b++)
      begin
         if (s[b])
         begin
            merge[8*b +: 8] = d[8*b +: 8];
         end
      end
   endfunction

   // ---------------------------------------------------------------
   // Timestamp FIFO
   // ---------------------------------------------------------------
   // identifier with timestamp
   ptsrw_ts_fifo #(
      .DEPTH_LOG2(FIFO_DEPTH_LOG2),
      .WIDTH(ID_W + TS_W)
   ) u_fifo (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .push_valid_i(r.o_save),
      .push_data_i({r.o_id, r.o_field[31:0]}),
      .push_ready_o(fifo_ready),
      .pop_i(r.pop),
      .head_o(fifo_head),
      .empty_o(fifo_empty),
      .count_o(fifo_cnt)
   );
   assign fifo_drop = r.o_save && !fifo_ready;

   assign cur_ns = frm_egress_i ? raw_capture_nanoseconds_i + r.local_corr
                                : raw_capture_nanoseconds_i - r.local_corr;
   assign adj_ns = cur_ns - r.path_delay - r.asym;

   assign s_axi_awready_o = !r.aw_got && !r.bvalid;
   assign s_axi_wready_o = !r.w_got && !r.bvalid;
   assign s_axi_bvalid_o = r.bvalid;
   assign s_axi_bresp_o = r.bresp;
   assign s_axi_arready_o = !r.rvalid;
   assign s_axi_rvalid_o = r.rvalid;
   assign s_axi_rdata_o = r.rdata;
   assign s_axi_rresp_o = r.rresp;
   assign rw_valid_o = r.o_v;
   assign rw_action_o = r.o_act;
   assign rw_offset_o = r.o_ofs;
   assign rw_size_o = r.o_size;
   assign rw_field_o = r.o_field;
   assign save_timestamp_o = r.o_save;
   assign aux_valid_o = r.o_aux_v;
   assign aux_offset_o = r.o_aux_ofs;
   assign aux_size_o = r.o_aux_size;
   assign aux_field_o = r.o_aux_val;

   always_comb
   begin
      n = r;
      n.pop = 1'b0;
      // ------------------------------------------------------------
      // Register bus
      // ------------------------------------------------------------
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
         n.aw_got = 1'b1;
         n.aw_addr = word_addr(s_axi_awaddr_i);
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
         n.w_got = 1'b1;
         n.w_data = s_axi_wdata_i;
         n.w_strb = s_axi_wstrb_i;
      end
      if (r.bvalid && s_axi_bready_i)
      begin
         n.bvalid = 1'b0;
      end
      if (r.aw_got && r.w_got)
      begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = RESP_OKAY;
         case (r.aw_addr)
            REG_CTRL: n.ctrl = 3'(merge({29'h0, r.ctrl}, r.w_data, r.w_strb));
            REG_PATH: n.path_delay = merge(r.path_delay, r.w_data, r.w_strb);
            REG_ASYM: n.asym = merge(r.asym, r.w_data, r.w_strb);
            REG_LCORR: n.local_corr = merge(r.local_corr, r.w_data, r.w_strb);
            REG_STATUS:
            begin
               if (r.w_strb[0] && r.w_data[STAT_OVF_BIT])
               begin
                  n.ovf = 1'b0;
               end
            end
            REG_POP: n.pop = 1'b1;
            REG_FTS, REG_ID0, REG_ID1, REG_ID2: n.bresp = RESP_OKAY;
            default: n.bresp = RESP_SLVERR;
         endcase
      end
      // Set after clear so a drop in the clearing cycle stays flagged
      if (fifo_drop)
      begin
         n.ovf = 1'b1;
      end
      if (r.rvalid && s_axi_rready_i)
      begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid_i && s_axi_arready_o)
      begin
         n.rvalid = 1'b1;
         n.rresp = RESP_OKAY;
         n.rdata = REG_RST;
         case (word_addr(s_axi_araddr_i))
            REG_CTRL: n.rdata = {29'h0, r.ctrl};
            REG_PATH: n.rdata = r.path_delay;
            REG_ASYM: n.rdata = r.asym;
            REG_LCORR: n.rdata = r.local_corr;
            REG_STATUS:
            begin
               n.rdata[STAT_EMPTY_BIT] = fifo_empty;
               n.rdata[STAT_OVF_BIT] = r.ovf;
               n.rdata[STAT_CNT_LSB +: FIFO_DEPTH_LOG2+1] = fifo_cnt;
            end
            REG_FTS: n.rdata = fifo_head[31:0];
            REG_ID0: n.rdata = fifo_head[63:32];
            REG_ID1: n.rdata = fifo_head[95:64];
            REG_ID2: n.rdata = {16'h0, fifo_head[111:96]};
            REG_POP: n.rdata = REG_RST;
            default: n.rresp = RESP_SLVERR;
         endcase
      end
      // ------------------------------------------------------------
      // Stage 1: action decode and capture
      // ------------------------------------------------------------
      n.s1_v = frm_valid_i;
      n.s1_act = ACT_NONE;
      n.s1_ofs = 8'h00;
      n.s1_size = NO_SIZE;
      n.s1_cf = frm_cf_i;
      n.s1_cur = cur_ns;
      n.s1_adj = adj_ns;
      n.s1_aux_v = 1'b0;
      n.s1_aux_ofs = 8'h00;
      n.s1_aux_size = NO_SIZE;
      n.s1_aux_val = 64'h0;
      n.s1_id = r.ctrl[CTRL_ID_RSV_BIT] ? {frm_id_i[ID_W-1:32], frm_rsv_i} : frm_id_i;
      if (frm_valid_i && frm_match_i && r.ctrl[CTRL_EN_BIT])
      begin
         if (!r.ctrl[CTRL_TWO_STEP_BIT] && !frm_egress_i)
         begin
            case (frm_type_i)
               FT_SYNC:
               begin
                  n.s1_act = ACT_SUB_PEER;
                  n.s1_ofs = frm_hdr_ofs_i + CF_OFS;
                  n.s1_size = CF_SIZE;
               end
               FT_PDELAY_REQ, FT_PDELAY_RESP:
               begin
                  n.s1_act = ACT_WRITE;
                  n.s1_ofs = frm_hdr_ofs_i + RSV_OFS;
                  n.s1_size = RSV_SIZE;
               end
               default: n.s1_act = ACT_NONE;
            endcase
         end
         else if (!r.ctrl[CTRL_TWO_STEP_BIT])
         begin
            case (frm_type_i)
               // add on egress Sync; host pre-subtracts Pdelay_resp
               FT_SYNC, FT_PDELAY_RESP:
               begin
                  n.s1_act = ACT_ADD;
                  n.s1_ofs = frm_hdr_ofs_i + CF_OFS;
                  n.s1_size = CF_SIZE;
               end
               FT_PDELAY_REQ:
               begin
                  n.s1_act = ACT_WRITE_SAVE;
                  n.s1_cf = 64'h0;
               end
               default: n.s1_act = ACT_NONE;
            endcase
         end
         else if (frm_type_i == FT_SYNC || frm_type_i == FT_DELAY_REQ)
         begin
            if (!frm_egress_i)
            begin
               n.s1_act = ACT_WRITE;
               n.s1_ofs = frm_hdr_ofs_i + RSV_OFS;
               n.s1_size = RSV_SIZE;
               if (frm_type_i == FT_SYNC)
               begin
                  n.s1_aux_v = 1'b1;
                  n.s1_aux_ofs = frm_hdr_ofs_i + CF_OFS;
                  n.s1_aux_size = CF_SIZE;
                  n.s1_aux_val = frm_cf_i + {32'h0, r.asym};
               end
            end
            else
            begin
               n.s1_act = ACT_WRITE_SAVE;
               n.s1_aux_v = 1'b1;
               n.s1_aux_ofs = frm_hdr_ofs_i + RSV_OFS;
               n.s1_aux_size = RSV_SIZE;
            end
         end
      end
      if (n.s1_act == ACT_NONE)
      begin
         n.s1_cur = 32'h0;
         n.s1_adj = 32'h0;
         n.s1_cf = 64'h0;
      end
      // ------------------------------------------------------------
      // Stage 2: replacement value
      // ------------------------------------------------------------
      n.o_v = r.s1_v;
      n.o_act = r.s1_act;
      n.o_ofs = r.s1_ofs;
      n.o_size = r.s1_size;
      n.o_id = r.s1_id;
      n.o_save = r.s1_v && (r.s1_act == ACT_WRITE_SAVE);
      n.o_aux_v = r.s1_v && r.s1_aux_v;
      n.o_aux_ofs = r.s1_aux_ofs;
      n.o_aux_size = r.s1_aux_size;
      n.o_aux_val = r.s1_aux_val;
      case (r.s1_act)
         ACT_SUB_PEER: n.o_field = r.s1_cf - {32'h0, r.s1_adj};
         ACT_WRITE, ACT_WRITE_SAVE: n.o_field = {32'h0, r.s1_cur};
         ACT_ADD: n.o_field = r.s1_cf + {32'h0, r.s1_cur};
         default: n.o_field = 64'h0;
      endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!resetn_i)
      begin
         r <= '0;
         r.ctrl <= CTRL_RST;
      end
      else
      begin
         r <= n;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_hit(logic eg, logic two, logic [1:0] ft);
      frm_valid_i && frm_match_i && r.ctrl[CTRL_EN_BIT] && frm_egress_i == eg
      && r.ctrl[CTRL_TWO_STEP_BIT] == two && frm_type_i == ft;
   endsequence
   sequence s_stable_cfg;
      $stable(r.local_corr) [*3] ##0 $stable(r.path_delay) ##0 $stable(r.asym);
   endsequence

   property p_in_sync;
      s_hit(1'b0, 1'b0, FT_SYNC) |-> ##2 rw_valid_o && rw_action_o == ACT_SUB_PEER
         && rw_size_o == CF_SIZE && rw_offset_o == $past(frm_hdr_ofs_i, 2) + CF_OFS;
   endproperty
   a_in_sync: assert property (p_in_sync) else $error("ingress sync action wrong");
   property p_in_pdly;
      s_hit(1'b0, 1'b0, FT_PDELAY_RESP) |-> ##2 rw_action_o == ACT_WRITE
         && rw_size_o == RSV_SIZE;
   endproperty
   a_in_pdly: assert property (p_in_pdly) else $error("pdelay write wrong");
   property p_sub;
      s_hit(1'b0, 1'b0, FT_SYNC) ##0 s_stable_cfg |-> rw_field_o == $past(frm_cf_i, 2)
         - {32'h0, $past(raw_capture_nanoseconds_i, 2) - r.local_corr - r.path_delay - r.asym};
   endproperty
   a_sub: assert property (p_sub) else $error("subtract value wrong");
   property p_add;
      s_hit(1'b1, 1'b0, FT_SYNC) ##0 s_stable_cfg |-> rw_action_o == ACT_ADD
         && rw_field_o == $past(frm_cf_i, 2) + {32'h0, $past(raw_capture_nanoseconds_i, 2)
         + r.local_corr};
   endproperty
   a_add: assert property (p_add) else $error("add value wrong");
   property p_wsave;
      s_hit(1'b1, 1'b0, FT_PDELAY_REQ) |-> ##2 save_timestamp_o && rw_size_o == NO_SIZE
         && rw_action_o == ACT_WRITE_SAVE && rw_field_o[63:32] == 32'h0;
   endproperty
   a_wsave: assert property (p_wsave) else $error("write-save wrong");
   property p_two_in;
      s_hit(1'b0, 1'b1, FT_SYNC) |-> ##2 rw_action_o == ACT_WRITE && aux_valid_o
         && aux_field_o == $past(frm_cf_i, 2) + {32'h0, r.asym};
   endproperty
   a_two_in: assert property (p_two_in) else $error("two-step ingress wrong");
   property p_two_out;
      s_hit(1'b1, 1'b1, FT_DELAY_REQ) |-> ##2 save_timestamp_o && aux_valid_o
         && aux_size_o == RSV_SIZE && aux_field_o == 64'h0 && rw_size_o == NO_SIZE;
   endproperty
   a_two_out: assert property (p_two_out) else $error("two-step egress wrong");
   property p_unmatched;
      frm_valid_i && !frm_match_i |-> ##2 rw_valid_o && rw_action_o == ACT_NONE
         && rw_size_o == NO_SIZE && rw_field_o == 64'h0 && !save_timestamp_o;
   endproperty
   a_unmatched: assert property (p_unmatched) else $error("unmatched modified");
   property p_ovf;
      // A pop in the drop cycle still moves the count
      fifo_drop && !r.pop |=> r.ovf && $stable(fifo_cnt);
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow not flagged");
endmodule // ptsrw_core
`default_nettype wire

// ---- core/ptsrw_ts_fifo.sv ----
/*
 * Transmit timestamp FIFO: identifier plus timestamp entries.
 * Assumes push and pop come from logic on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module ptsrw_ts_fifo
   import ptsrw_pkg::*;
#(
   parameter int DEPTH_LOG2 = 3,
   parameter int WIDTH = ID_W + TS_W
)
(
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic push_valid_i,
   input wire logic [WIDTH-1:0] push_data_i,
   output logic push_ready_o,
   input wire logic pop_i,
   output logic [WIDTH-1:0] head_o,
   output logic empty_o,
   output logic [DEPTH_LOG2:0] count_o
);
   localparam int DEPTH = 1 << DEPTH_LOG2;
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [DEPTH_LOG2-1:0] wp;
      logic [DEPTH_LOG2-1:0] rp;
      logic [DEPTH_LOG2:0] cnt;
   } ptsrw_fifo_st_t;
   ptsrw_fifo_st_t r, n;
   logic full;
   logic do_push;
   logic do_pop;

   assign full = r.cnt[DEPTH_LOG2];
   assign do_push = push_valid_i && !full;
   assign do_pop = pop_i && (r.cnt != '0);
   assign push_ready_o = !full;
   assign empty_o = (r.cnt == '0);
   assign head_o = r.mem[r.rp];
   assign count_o = r.cnt;

   always_comb
   begin
      n = r;
      if (do_push)
      begin
         n.mem[r.wp] = push_data_i;
         n.wp = r.wp + 1'b1;
      end
      if (do_pop)
      begin
         n.rp = r.rp + 1'b1;
      end
      if (do_push && !do_pop)
      begin
         n.cnt = r.cnt + 1'b1;
      end
      else if (!do_push && do_pop)
      begin
         n.cnt = r.cnt - 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!resetn_i)
      begin
         r <= '0;
      end
      else
      begin
         r <= n;
      end
   end
endmodule // ptsrw_ts_fifo
`default_nettype wire

// ---- verification/ptsrw_core_tb.sv ----
/*
 * Self-checking bench for the timestamp action and FIFO logic.
 * Assumes the host model drives the register bus.
 */
`timescale 1ns/10ps
`default_nettype none
module ptsrw_core_tb;
   import ptsrw_pkg::*;
   localparam logic [31:0] RAW = 32'h0000_1000, LC = 32'h0000_0010;
   localparam logic [31:0] PD = 32'h0000_0100, AS = 32'h0000_0020, RSV = 32'hA5A5_0F0F;
   localparam logic [63:0] CF = 64'h0000_0000_0000_5000;
   localparam logic [7:0] H = 8'h0E;
   localparam logic [79:0] ID = 80'h1234_5678_9ABC_DEF0_1357;
   logic clk, resetn, awv, awr, wv, wr_, bv, bre, arv, arr, rv, rre, fv, fm, fe;
   logic [7:0] aw, ar, rwo, axo;
   logic [31:0] wd, rdt;
   logic [1:0] br, rr, ft;
   logic [63:0] fc, rwf, axf;
   logic [3:0] rws, axs;
   logic rwv, sv, axv;
   ptsrw_act_t rwa;
   int fails, comparisons;
   ptsrw_core #(.FIFO_DEPTH_LOG2(3)) dut (.ref_clk_i(clk), .resetn_i(resetn),
      .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_),
      .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
      .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rdt), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre),
      .frm_valid_i(fv), .frm_match_i(fm), .frm_egress_i(fe), .frm_type_i(ft),
      .frm_hdr_ofs_i(H), .frm_cf_i(fc), .frm_id_i(ID), .frm_rsv_i(RSV),
      .raw_capture_nanoseconds_i(RAW), .rw_valid_o(rwv), .rw_action_o(rwa),
      .rw_offset_o(rwo), .rw_size_o(rws), .rw_field_o(rwf), .save_timestamp_o(sv),
      .aux_valid_o(axv), .aux_offset_o(axo), .aux_size_o(axs), .aux_field_o(axf));
   ptsrw_host_model host (.ref_clk_i(clk), .awaddr_o(aw), .awvalid_o(awv),
      .awready_i(awr), .wdata_o(wd), .wvalid_o(wv), .wready_i(wr_), .bresp_i(br),
      .bvalid_i(bv), .bready_o(bre), .araddr_o(ar), .arvalid_o(arv), .arready_i(arr),
      .rdata_i(rdt), .rresp_i(rr), .rvalid_i(rv), .rready_o(rre));
   always #50 clk = ~clk;
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic cmp(input logic [63:0] g, input logic [63:0] e);
      comparisons++;
      if (g !== e)
      begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      host.wr(a, d, r);
      cmp(r, er);
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      host.rd(a, d, r);
      cmp(r, RESP_OKAY);
      cmp(d, e);
   endtask
   // Descriptor in, patch judged two cycles later
   task automatic fr(input logic m, e, input ptsrw_ftype_t t, input logic [63:0] c,
                     input ptsrw_act_t a, input logic [7:0] o, input logic [3:0] s,
                     input logic [63:0] f, input logic v);
      @(posedge clk);
      {fv, fm, fe, ft, fc} <= {1'b1, m, e, t, c};
      @(posedge clk);
      fv <= 1'b0;
      // Patch stands for the one cycle after this edge
      @(posedge clk);
      #1;
      cmp(rwv, 1'b1);
      cmp({rwa, rwo, rws, sv}, {a, o, s, v});
      cmp(rwf, f);
   endtask
   task automatic ax(input logic [7:0] o, input logic [3:0] s, input logic [63:0] f);
      cmp({axv, axo, axs}, {1'b1, o, s});
      cmp(axf, f);
   endtask
   task automatic conclude();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      rreg(REG_CTRL, {29'h0, CTRL_RST});
      wreg(8'hFC, 32'h1, RESP_SLVERR);
      wreg(REG_PATH, PD, RESP_OKAY);
      wreg(REG_ASYM, AS, RESP_OKAY);
      wreg(REG_LCORR, LC, RESP_OKAY);
      rreg(REG_STATUS, 32'h1);
      $display("test regs done");
   endtask
   task automatic t_peer();
      fr(1, 0, FT_SYNC, CF, ACT_SUB_PEER, H + CF_OFS, CF_SIZE, CF-(RAW-LC-PD-AS), 0);
      fr(1, 0, FT_PDELAY_REQ, CF, ACT_WRITE, H + RSV_OFS, RSV_SIZE, RAW - LC, 0);
      fr(1, 0, FT_PDELAY_RESP, CF, ACT_WRITE, H + RSV_OFS, RSV_SIZE, RAW - LC, 0);
      fr(1, 1, FT_SYNC, CF, ACT_ADD, H + CF_OFS, CF_SIZE, CF + RAW + LC, 0);
      fr(1, 1, FT_PDELAY_RESP, CF-(RAW-LC), ACT_ADD, H + CF_OFS, CF_SIZE, CF+2*LC, 0);
      fr(1, 1, FT_PDELAY_REQ, 0, ACT_WRITE_SAVE, 0, NO_SIZE, RAW + LC, 1);
      fr(0, 1, FT_SYNC, CF, ACT_NONE, 0, NO_SIZE, 0, 0);
      rreg(REG_STATUS, 32'h100);
      rreg(REG_FTS, RAW + LC);
      rreg(REG_ID0, ID[31:0]);
      rreg(REG_ID2, {16'h0, ID[79:64]});
      wreg(REG_POP, 32'h0, RESP_OKAY);
      rreg(REG_STATUS, 32'h1);
      $display("test peer done");
   endtask
   task automatic t_two();
      wreg(REG_CTRL, 32'h7, RESP_OKAY);
      fr(1, 0, FT_SYNC, CF, ACT_WRITE, H + RSV_OFS, RSV_SIZE, RAW - LC, 0);
      ax(H + CF_OFS, CF_SIZE, CF + AS);
      fr(1, 0, FT_DELAY_REQ, CF, ACT_WRITE, H + RSV_OFS, RSV_SIZE, RAW - LC, 0);
      repeat (9)
      begin
         fr(1, 1, FT_DELAY_REQ, 0, ACT_WRITE_SAVE, 0, NO_SIZE, RAW + LC, 1);
         ax(H + RSV_OFS, RSV_SIZE, 0);
      end
      rreg(REG_STATUS, 32'h802);
      rreg(REG_ID0, RSV);
      rreg(REG_ID1, ID[63:32]);
      wreg(REG_STATUS, 32'h2, RESP_OKAY);
      rreg(REG_STATUS, 32'h800);
      // Disabled block must leave matched frames alone
      wreg(REG_CTRL, 32'h0, RESP_OKAY);
      fr(1, 0, FT_SYNC, CF, ACT_NONE, 0, NO_SIZE, 0, 0);
      $display("test two-step done");
   endtask
   initial
   begin
      {clk, resetn, fv, fm, fe, ft, fc} = '0;
      fails = 0;
      comparisons = 0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      t_regs();
      t_peer();
      t_two();
      conclude();
   end
   // Whole run needs well under a thousand cycles
   initial
   begin
      #200000;
      fails++;
      conclude();
   end
endmodule // ptsrw_core_tb
`default_nettype wire

// ---- verification/ptsrw_host_model.sv ----
/*
 * Host engine model: AXI4-Lite master that reads the timestamp FIFO.
 * Assumes a slave on ref_clk_i; tasks are entered just after an edge.
 */
`timescale 1ns/10ps
`default_nettype none
module ptsrw_host_model
(
   input wire logic ref_clk_i,
   output logic [7:0] awaddr_o,
   output logic awvalid_o,
   input wire logic awready_i,
   output logic [31:0] wdata_o,
   output logic wvalid_o,
   input wire logic wready_i,
   input wire logic [1:0] bresp_i,
   input wire logic bvalid_i,
   output logic bready_o,
   output logic [7:0] araddr_o,
   output logic arvalid_o,
   input wire logic arready_i,
   input wire logic [31:0] rdata_i,
   input wire logic [1:0] rresp_i,
   input wire logic rvalid_i,
   output logic rready_o
);
   logic done;
   initial
   begin
      {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
      {araddr_o, arvalid_o, rready_o} = '0;
   end
   // Released payload inverted so stale values cannot match
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      // One edge between transfers so no signal is assigned twice at once
      @(posedge ref_clk_i);
      done = 1'b0;
      awaddr_o <= a;
      wdata_o <= d;
      awvalid_o <= 1'b1;
      wvalid_o <= 1'b1;
      bready_o <= 1'b1;
      while (!done)
      begin
         @(posedge ref_clk_i);
         if (awvalid_o && awready_i)
            awvalid_o <= 1'b0;
         if (wvalid_o && wready_i)
            wvalid_o <= 1'b0;
         done = bvalid_i;
      end
      r = bresp_i;
      bready_o <= 1'b0;
      awaddr_o <= ~a;
      wdata_o <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk_i);
      done = 1'b0;
      araddr_o <= a;
      arvalid_o <= 1'b1;
      rready_o <= 1'b1;
      while (!done)
      begin
         @(posedge ref_clk_i);
         if (arvalid_o && arready_i)
            arvalid_o <= 1'b0;
         done = rvalid_i;
      end
      d = rdata_i;
      r = rresp_i;
      rready_o <= 1'b0;
      araddr_o <= ~a;
   endtask
endmodule // ptsrw_host_model
`default_nettype wire
